/* File: atten_pkg.sv */
// Operation
// R1 - only a valid channel address changes a channel; other addresses change nothing
// R2 - attenuation codes 0x4f through 0xff mute the addressed channel
// R3 - mute is accepted from any current setting, switching straight into mute
// R4 - controller holds load/shift low from before first clock through sixteen bits
// R5 - each word is an 8-bit channel field and an 8-bit attenuation field
// R6 - address byte goes first, each byte most significant bit first
// R7 - address 0x00 selects channel one, 0x01 channel two, 0x02 channel three
// R8 - codes give 0.5 dB, then 1 dB, then 2 dB steps up to 76 dB
// R9 - earlier register contents leave on the serial output while new bits enter
// R10 - rising load/shift latches the word, decodes it and sets the chosen tap
// R11 - channels not addressed keep their setting; change only when selected or powered up
// R12 - at power-up all three channels are muted
// R13 - serial input is captured on each rising edge of the serial clock
// R14 - shifting happens only while load/shift is low
// R15 - a chain of n devices takes 16n bits, then one rising load/shift
// R16 - serial output is the bit at the far end of the 16-bit register
// R17 - clock edges with load/shift high neither shift nor change settings
package atten_pkg;
  localparam int WORD_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam int NUM_CHANNELS = 3;
  localparam int ADDR_MSB = 15;
  localparam int ADDR_LSB = 8;
  localparam int CODE_MSB = 7;
  localparam int CODE_LSB = 0;
  localparam logic [7:0] CHAN1_ADDR = 8'h00;
  localparam logic [7:0] CHAN2_ADDR = 8'h01;
  localparam logic [7:0] CHAN3_ADDR = 8'h02;
  localparam logic [7:0] HALF_DB_LAST = 8'h1f;
  localparam logic [7:0] ONE_DB_LAST = 8'h3f;
  localparam logic [7:0] TWO_DB_LAST = 8'h4e;
  localparam logic [7:0] MUTE_FIRST = 8'h4f;
  localparam logic [7:0] MUTE_CODE_RESET = 8'hff;
  localparam logic [15:0] SHIFT_RESET = 16'h0000;
  // attenuation in half-dB units, 76 dB = 152
  localparam logic [7:0] ATT_MUTE_HALFDB = 8'hff;
  typedef logic [7:0] byte_t;
endpackage

/* File: pin_sync.sv */
`timescale 1ns/100ps
module pin_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // pins
  input  wire logic pinIn,
  output logic      pinOut
);
  logic meta_r, meta_nxt;
  logic sync_r, sync_nxt;
  always_comb begin
    meta_nxt = pinIn;
    // in reset both stages follow the pin, so release shows the idle level
    // and the edge detectors behind see no false edge
    sync_nxt = rst ? pinIn : meta_r;
  end
  always_ff @(posedge clk) begin
    meta_r <= meta_nxt;
    sync_r <= sync_nxt;
  end
  assign pinOut = sync_r;
endmodule

/* File: atten_decode.sv */
`timescale 1ns/100ps
module atten_decode (
  // code in
  input  wire atten_pkg::byte_t code,
  // decoded tap
  output logic                  mute,
  output atten_pkg::byte_t      halfDb
);
  import atten_pkg::*;
  always_comb begin
    mute   = 1'b0;
    halfDb = 8'h00;
    if (code <= HALF_DB_LAST) begin // R8
      halfDb = code;
    end else if (code <= ONE_DB_LAST) begin
      halfDb = 8'(8'h20 + 8'(2 * (code - 8'h20)));
    end else if (code <= TWO_DB_LAST) begin
      halfDb = 8'(8'h60 + 8'(4 * (code - 8'h40)));
    end else begin
      mute   = 1'b1; // R2
      halfDb = ATT_MUTE_HALFDB;
    end
  end
endmodule

/* File: serial_attenuator_control.sv */
`timescale 1ns/100ps
module serial_attenuator_control (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // serial link pins
  input  wire logic                          serClk,
  input  wire logic                          loadShift,
  input  wire logic                          dataIn,
  output logic                               dataOut,
  // per-channel tap selection
  output atten_pkg::byte_t                   chanCode [atten_pkg::NUM_CHANNELS],
  output atten_pkg::byte_t                   chanHalfDb [atten_pkg::NUM_CHANNELS],
  output logic [atten_pkg::NUM_CHANNELS-1:0] chanMute
);
  import atten_pkg::*;

  // synchronised copies of the pins
  logic        clkS;
  logic        ldS;
  logic        dinS;

  pin_sync syncClk (
    .clk    (clk),
    .rst    (rst),
    .pinIn  (serClk),
    .pinOut (clkS)
  );

  pin_sync syncLd (
    .clk    (clk),
    .rst    (rst),
    .pinIn  (loadShift),
    .pinOut (ldS)
  );

  pin_sync syncDin (
    .clk    (clk),
    .rst    (rst),
    .pinIn  (dataIn),
    .pinOut (dinS)
  );

  // edge detection state
  logic        clkPrev_r;
  logic        clkPrev_nxt;
  logic        ldPrev_r;
  logic        ldPrev_nxt;
  logic        clkRise;
  logic        ldRise;

  // shift register state
  logic [15:0] shift_r;
  logic [15:0] shift_nxt;
  logic        shiftEn;
  byte_t       addrByte;
  byte_t       codeByte;

  // channel settings state
  byte_t       code_r [NUM_CHANNELS];
  byte_t       code_nxt [NUM_CHANNELS];
  int          selIdx;
  logic        latchEn;
  logic [23:0] codeFlat;

  function automatic int chanIndex(input byte_t a);
    unique case (a)
      CHAN1_ADDR: chanIndex = 0; // R7
      CHAN2_ADDR: chanIndex = 1;
      CHAN3_ADDR: chanIndex = 2;
      default:    chanIndex = -1; // R1
    endcase
  endfunction

  function automatic logic validAddr(input byte_t a);
    validAddr = (chanIndex(a) >= 0);
  endfunction

  // previous samples reset to the idle pin levels, so leaving reset
  // never looks like an edge
  always_comb begin
    clkPrev_nxt = clkS;
    ldPrev_nxt  = ldS;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clkPrev_r <= 1'b0;
      ldPrev_r  <= 1'b1;
    end else begin
      clkPrev_r <= clkPrev_nxt;
      ldPrev_r  <= ldPrev_nxt;
    end
  end

  assign clkRise = clkS & ~clkPrev_r;
  assign ldRise  = ldS & ~ldPrev_r;

  assign shiftEn  = clkRise & ~ldS; // R13 R14 R17
  assign addrByte = shift_r[ADDR_MSB:ADDR_LSB]; // R5 R6
  assign codeByte = shift_r[CODE_MSB:CODE_LSB];

  always_comb begin
    shift_nxt = shift_r;
    if (shiftEn) begin // R9
      shift_nxt = {shift_r[WORD_BITS-2:0], dinS};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      shift_r <= SHIFT_RESET;
    end else begin
      shift_r <= shift_nxt;
    end
  end

  // the chained device sees the oldest bit, straight from a flip-flop
  assign dataOut = shift_r[WORD_BITS-1]; // R16

  assign selIdx  = chanIndex(addrByte);
  assign latchEn = ldRise & validAddr(addrByte); // R10 R1

  always_comb begin
    code_nxt = code_r;
    // any code, mute included, replaces the current one directly
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      if (latchEn && selIdx == i) begin // R3 R11
        code_nxt[i] = codeByte;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        code_r[i] <= MUTE_CODE_RESET; // R12
      end
    end else begin
      code_r <= code_nxt;
    end
  end

  assign codeFlat = {code_r[2], code_r[1], code_r[0]};

  for (genvar g = 0; g < NUM_CHANNELS; g++) begin : gDec
    atten_decode dec (
      .code   (code_r[g]),
      .mute   (chanMute[g]),
      .halfDb (chanHalfDb[g])
    );
    assign chanCode[g] = code_r[g];
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence shiftEdge;
    clkRise && !ldS;
  endsequence

  sequence blockedEdge;
    clkRise && ldS;
  endsequence

  sequence heldHigh;
    ldS && !ldRise;
  endsequence

  sequence badLatch;
    ldRise && !validAddr(addrByte);
  endsequence

  sequence latchCh1;
    ldRise && addrByte == CHAN1_ADDR;
  endsequence

  sequence latchCh2;
    ldRise && addrByte == CHAN2_ADDR;
  endsequence

  sequence latchCh3;
    ldRise && addrByte == CHAN3_ADDR;
  endsequence

  sequence muteCode;
    codeByte >= MUTE_FIRST;
  endsequence

  // shifting: only a detected rise with load/shift low moves the register
  shift_in_a: assert property ( // R13
    shiftEdge
    |=> shift_r[0] == $past(dinS))
    else $error("serial bit not captured");

  shift_out_a: assert property ( // R9
    shiftEdge
    |=> dataOut == $past(shift_r[14]))
    else $error("earlier bit not shifted out");

  shift_gate_a: assert property ( // R14
    blockedEdge
    |=> $stable(shift_r))
    else $error("clock edge shifted with load/shift high");

  idle_shift_a: assert property ( // R13
    !clkRise
    |=> $stable(shift_r))
    else $error("register moved without a clock rise");

  hold_high_a: assert property ( // R17
    heldHigh
    |=> $stable(shift_r))
    else $error("register moved while load/shift high");

  out_hold_a: assert property ( // R16
    !clkRise
    |=> $stable(dataOut))
    else $error("serial output moved without a shift");

  // latching: one channel at a time, only on a valid address
  no_latch_a: assert property ( // R17
    !ldRise
    |=> codeFlat == $past(codeFlat))
    else $error("setting changed without latch");

  bad_addr_a: assert property ( // R1
    badLatch
    |=> $stable(codeFlat))
    else $error("invalid address changed a channel");

  latch_ch1_a: assert property ( // R10 R11
    latchCh1
    |=> code_r[0] == $past(codeByte)
      && code_r[1] == $past(code_r[1])
      && code_r[2] == $past(code_r[2]))
    else $error("channel one latch wrong");

  latch_ch2_a: assert property ( // R10
    latchCh2
    |=> code_r[1] == $past(codeByte)
      && code_r[0] == $past(code_r[0])
      && code_r[2] == $past(code_r[2]))
    else $error("channel two latch wrong");

  latch_ch3_a: assert property ( // R10 R11
    latchCh3
    |=> code_r[2] == $past(codeByte)
      && code_r[0] == $past(code_r[0])
      && code_r[1] == $past(code_r[1]))
    else $error("channel three latch wrong");

  mute_code_a: assert property ( // R2
    latchCh1 ##0 muteCode
    |=> chanMute[0])
    else $error("mute code did not mute");

  mute_ch3_a: assert property ( // R3
    latchCh3 ##0 muteCode
    |=> chanMute[2])
    else $error("channel three not muted from its setting");

  power_mute_a: assert property ( // R12
    disable iff (1'b0) $fell(rst)
    |-> chanMute == 3'b111)
    else $error("channels not muted after reset");

  // decode spot checks at each step size and at the mute tap
  step_half_a: assert property ( // R8
    code_r[0] == HALF_DB_LAST
    |-> chanHalfDb[0] == HALF_DB_LAST)
    else $error("half dB step decode wrong");

  step_one_a: assert property ( // R8
    code_r[1] == ONE_DB_LAST
    |-> chanHalfDb[1] == 8'h5e)
    else $error("1 dB step decode wrong");

  step_two_a: assert property ( // R8
    code_r[2] == TWO_DB_LAST
    |-> chanHalfDb[2] == 8'h98)
    else $error("2 dB step decode wrong");

  step_max_a: assert property ( // R8
    !chanMute[0]
    |-> chanHalfDb[0] <= 8'h98)
    else $error("attenuation beyond the last tap");

  mute_tap1_a: assert property ( // R2
    chanMute[0]
    |-> chanHalfDb[0] == ATT_MUTE_HALFDB)
    else $error("channel one mute tap wrong");

  mute_tap2_a: assert property ( // R2
    chanMute[1]
    |-> chanHalfDb[1] == ATT_MUTE_HALFDB)
    else $error("channel two mute tap wrong");

  mute_tap3_a: assert property ( // R2
    chanMute[2]
    |-> chanHalfDb[2] == ATT_MUTE_HALFDB)
    else $error("channel three mute tap wrong");
endmodule

/* File: uc_link.sv */
`timescale 1ns/100ps
module uc_link (
  // clock
  input  wire logic clk,
  // link pins
  output logic      serClk,
  output logic      loadShift,
  output logic      dataIn
);
  initial begin
    serClk = 1'b0;
    loadShift = 1'b1;
    dataIn = 1'b0;
  end
  // enLow low keeps loadShift high so the clocks must be ignored
  task automatic send(input logic [31:0] w, input int n, input logic enLow);
    loadShift = ~enLow;
    repeat (8) @(negedge clk);
    for (int i = n - 1; i >= 0; i--) begin
      dataIn = w[i];
      repeat (4) @(negedge clk);
      serClk = 1'b1;
      repeat (4) @(negedge clk);
      serClk = 1'b0;
    end
    // hold time over: show the inverse, never a stale bit
    dataIn = ~w[0];
    repeat (4) @(negedge clk);
    loadShift = 1'b1;
  endtask
endmodule

/* File: serial_attenuator_control_test.sv */
`timescale 1ns/100ps
module serial_attenuator_control_test;
  import atten_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        serClk, loadShift, dataIn, dataOut;
  byte_t       chanCode [NUM_CHANNELS];
  byte_t       chanHalfDb [NUM_CHANNELS];
  logic [2:0]  chanMute;
  logic [15:0] cap;
  int          n_mismatch = 0;
  int          compares = 0;
  always #12.5 clk = ~clk;
  // sampled at the next serClk rise after each shift, so dataOut has settled
  always @(posedge serClk) cap <= {cap[14:0], dataOut};
  uc_link mcu (.clk(clk), .serClk(serClk), .loadShift(loadShift), .dataIn(dataIn));
  serial_attenuator_control dut (.clk(clk), .rst(rst), .serClk(serClk),
    .loadShift(loadShift), .dataIn(dataIn), .dataOut(dataOut), .chanCode(chanCode),
    .chanHalfDb(chanHalfDb), .chanMute(chanMute));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chan(input int c, input byte_t d);
    byte_t hd;
    hd = d < 8'h20 ? d : d < 8'h40 ? byte_t'(8'h20 + 2 * (d - 8'h20)) :
         d < 8'h4f ? byte_t'(8'h60 + 4 * (d - 8'h40)) : 8'hff;
    chk({8'h00, chanCode[c]}, {8'h00, d});
    chk({8'h00, chanHalfDb[c]}, {8'h00, hd});
    chk({15'h0, chanMute[c]}, {15'h0, d >= 8'h4f});
  endtask
  task automatic put(input byte_t a, input byte_t d, input logic en);
    mcu.send({16'h0000, a, d}, 16, en);
    repeat (12) @(negedge clk);
  endtask
  task automatic t_taps();
    byte_t k [3] = '{8'h1f, 8'h3f, 8'h4e};
    for (int c = 0; c < 3; c++) begin
      put(byte_t'(c), k[c], 1'b1);
      for (int j = 0; j < 3; j++) chan(j, j <= c ? k[j] : 8'hff);
    end
  endtask
  task automatic t_refuse();
    put(8'h03, 8'h00, 1'b1);
    put(8'h01, 8'h00, 1'b0);
    chan(0, 8'h1f);
    chan(1, 8'h3f);
    chan(2, 8'h4e);
  endtask
  task automatic t_mute();
    put(8'h00, 8'h4f, 1'b1);
    put(8'h02, 8'hff, 1'b1);
    chan(0, 8'h4f);
    chan(2, 8'hff);
  endtask
  task automatic t_chain();
    // first word must pass through untouched; only the last one latches
    mcu.send(32'h0110_0205, 32, 1'b1);
    repeat (12) @(negedge clk);
    chk(cap, 16'h0110);
    chan(1, 8'h3f);
    chan(2, 8'h05);
  endtask
  task automatic wrap_up();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #400000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    for (int c = 0; c < 3; c++) chan(c, 8'hff);
    t_taps();
    t_refuse();
    t_mute();
    t_chain();
    wrap_up();
  end
endmodule
